// [logic/thpog_pkg.sv]
// Purpose: Shared constants and types for the transmit path overhead generator.
// Assumes: APB with 32-bit data; each register index maps to byte address index*4.
// Notes:   Register indexes are kept as printed; byte addresses are derived from them.
package thpog_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_PATH_CONFIG  = 8'h71;
  localparam logic [7:0]  IDX_C2_VALUE     = 8'h72;
  localparam logic [7:0]  IDX_K3_VALUE     = 8'h73;
  localparam logic [7:0]  IDX_RDI_VALUE    = 8'h74;
  localparam logic [7:0]  IDX_TRACE_CTL    = 8'h75;
  localparam logic [7:0]  IDX_TRACE_DATA   = 8'h76;
  localparam int          ADDR_W           = 10;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_PATH_CONFIG  = 8'h80;
  localparam logic [7:0]  RST_C2_VALUE     = 8'h01;
  localparam logic [7:0]  RST_K3_VALUE     = 8'h00;
  localparam logic [3:0]  RST_RDI_VALUE    = 4'h0;
  localparam logic        RST_SW_ACCESS    = 1'b1;

  // ---------------------------------------------------------------------------
  // Field positions in the path configuration and trace control registers
  // ---------------------------------------------------------------------------
  localparam int          CFG_MARKER       = 7;
  localparam int          CFG_UNEQ         = 6;
  localparam int          CFG_LEN          = 5;
  localparam int          CFG_AIS          = 4;
  localparam int          CFG_REI_SRC      = 3;
  localparam int          CFG_RDI_SRC      = 2;
  localparam int          CTL_ACCESS       = 1;
  localparam int          CTL_PTR_CLEAR    = 0;

  // ---------------------------------------------------------------------------
  // Byte values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  BYTE_ONES        = 8'hFF;
  localparam logic [7:0]  TRACE_IDLE       = 8'h01;
  localparam logic [5:0]  LEN_SHORT_LAST   = 6'h0F;
  localparam logic [5:0]  LEN_LONG_LAST    = 6'h3F;
  localparam int          TRACE_DEPTH      = 64;
  localparam logic [2:0]  RDI_SERVER       = 3'h5;
  localparam logic [2:0]  RDI_LABEL        = 3'h4;
  localparam logic [2:0]  RDI_CONNECT      = 3'h6;
  localparam logic [2:0]  RDI_NONE         = 3'h0;
  localparam logic [1:0]  INV_FOREVER      = 2'h2;
  localparam logic [1:0]  INV_ONCE         = 2'h3;
  localparam logic [1:0]  MFRAME_START     = 2'h0;
  localparam logic [1:0]  MARK_GAP         = 2'h2;

  // Overhead byte slot codes presented by the framer.
  typedef enum logic [3:0] {
    SLOT_J1 = 4'h0,
    SLOT_B3 = 4'h1,
    SLOT_C2 = 4'h2,
    SLOT_G1 = 4'h3,
    SLOT_F2 = 4'h4,
    SLOT_H4 = 4'h5,
    SLOT_F3 = 4'h6,
    SLOT_K3 = 4'h7,
    SLOT_N1 = 4'h8
  } thpog_slot_t;

endpackage : thpog_pkg

// [logic/thpog_top.sv]
// Purpose: Transmit higher-order path overhead generator with APB registers.
// Assumes: Framer strobes and alarm levels come from logic on clk; no synchronisers.
// Notes:   One overhead byte per slot strobe, output one cycle later from flops.
// Behaviour
// - Marker: single pulse at J1, or double pulse at multiframe start when set.
// - Unequipped: C2 and N1 are zero, B3 still valid.
// - Trace string length is 16 bytes or 64 bytes by length bit.
// - Force path AIS while all overhead passes through.
// - REI field from fed-back B3 errors, or zero when REI source set.
// - Hardware RDI sends 101 on AU alarm or pointer loss, top priority.
// - Next, label mismatch with enable sends 100.
// - Next, unequipped with enable or trace mismatch sends 110; else 000.
// - Software RDI source sends written RDI value and spare bit in G1.
// - B3 invert: 0X none, 10 always, 11 one frame only.
// - Software C2 inserted when C2 and pass-through selects are zero.
// - Software K3 inserted when K3 and pass-through selects are zero.
// - Access bit 0: hardware owns string; processor access leaves pointer.
// - Access bit 1: processor accesses advance pointer; J1 sends 01H.
// - Rising edge of pointer-clear bit returns pointer to string start.
// - Eight-bit data register reads or writes byte at current pointer.
// - Pass-through bit passes all received overhead; else per-byte selects.
// - G1 source: internal when 0, TPOH when 1; regenerator passes through.
// - Unequipped with zero-J1 bit set sends all zeros in J1.
`timescale 1ns/100ps
module thpog_top
  import thpog_pkg::*;
(
  input  wire logic                 clk,                      // 100 MHz frame clock.
  input  wire logic                 rst_n,                    // Async reset, active low.
  input  wire logic                 psel,                     // APB select.
  input  wire logic                 penable,                  // APB access phase.
  input  wire logic                 pwrite,                   // APB write when high.
  input  wire logic [thpog_pkg::ADDR_W-1:0] paddr,            // APB byte address.
  input  wire logic [31:0]          pwdata,                   // APB write data.
  output logic                      pready,                   // APB ready.
  output logic [31:0]               prdata,                   // APB read data.
  output logic                      pslverr,                  // APB error, unmapped.
  input  wire logic                 slot_valid,               // Overhead slot strobe.
  input  wire thpog_pkg::thpog_slot_t slot_sel,               // Which overhead byte.
  input  wire logic [1:0]           mframe_phase,             // H4 low bits this frame.
  input  wire logic [7:0]           rx_poh_byte,              // Received byte, same slot.
  input  wire logic [7:0]           tpoh_byte,                // TPOH input byte.
  input  wire logic [7:0]           b3_calc,                  // Computed B3 parity.
  input  wire logic [3:0]           b3_err_count,             // Far-end B3 errors, 0-8.
  input  wire logic                 regen_mode,               // Regenerator configuration.
  input  wire logic                 poh_passthru_sel,         // All overhead passed through.
  input  wire logic                 status_byte_source,       // G1 from TPOH when high.
  input  wire logic                 label_byte_source,        // C2 from TPOH when high.
  input  wire logic                 aps_byte_source,          // K3 from TPOH when high.
  input  wire logic                 trace_byte_source,        // J1 from TPOH when high.
  input  wire logic                 unequipped_trace_zero,    // Zero J1 when unequipped.
  input  wire logic                 au_alarm_status,          // AU AIS status.
  input  wire logic                 pointer_loss_status,      // Loss of pointer status.
  input  wire logic                 rdi_on_label_mismatch_en, // RDI on label mismatch.
  input  wire logic                 label_mismatch_status,    // Label mismatch status.
  input  wire logic                 rdi_on_unequipped_en,     // RDI on unequipped.
  input  wire logic                 unequipped_rx_status,     // Unequipped status.
  input  wire logic                 trace_mismatch_status,    // Trace mismatch status.
  output logic [7:0]                poh_byte,                 // Generated overhead byte.
  output logic                      poh_byte_valid,           // Pulse with poh_byte.
  output logic                      path_ais_out,             // Level: send path AIS.
  output logic                      tbus_frame_marker_out     // Telecom-bus J1 marker.
);
  import thpog_pkg::*;

  // ---------------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------------
  // Byte address of a register index; indexes are not word aligned.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  // Next trace pointer, wrapping at the configured length.
  function automatic logic [5:0] ptr_step(input logic [5:0] p, input logic long_len);
    logic [5:0] last;
    last = long_len ? LEN_LONG_LAST : LEN_SHORT_LAST;
    ptr_step = (p >= last) ? 6'h00 : p + 6'h01;
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [7:0]  path_config;
  logic [7:0]  c2_value;
  logic [7:0]  k3_value;
  logic [3:0]  rdi_value;
  logic        trace_sw_access;
  logic        trace_ptr_clear;
  logic [5:0]  trace_ptr;
  logic        inv_once_done;
  logic [7:0]  next_path_config;
  logic [7:0]  next_c2_value;
  logic [7:0]  next_k3_value;
  logic [3:0]  next_rdi_value;
  logic        next_trace_sw_access;
  logic        next_trace_ptr_clear;
  logic [5:0]  next_trace_ptr;
  logic        next_inv_once_done;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [7:0]  trace_mem [TRACE_DEPTH];

  logic        acc_done;
  logic        hit_data;
  logic        j1_take;
  logic        b3_slot;
  logic [1:0]  parity_invert_ctl;
  logic        send_unequipped;
  logic        trace_len_sel;
  logic        force_path_ais;
  logic        rei_source_sel;
  logic        rdi_source_sel;

  assign acc_done          = psel & penable & pready;
  assign hit_data          = (paddr == reg_addr(IDX_TRACE_DATA));
  assign j1_take           = slot_valid & (slot_sel == SLOT_J1);
  assign b3_slot           = slot_valid & (slot_sel == SLOT_B3);
  assign parity_invert_ctl = path_config[1:0];
  assign send_unequipped   = path_config[CFG_UNEQ];
  assign trace_len_sel     = path_config[CFG_LEN];
  assign force_path_ais    = path_config[CFG_AIS];
  assign rei_source_sel    = path_config[CFG_REI_SRC];
  assign rdi_source_sel    = path_config[CFG_RDI_SRC];

  // ---------------------------------------------------------------------------
  // APB slave and pointer control
  // ---------------------------------------------------------------------------
  // One wait state: read data is registered in the first access cycle so that
  // prdata always comes from flops, at the cost of a three-cycle transfer.
  always_comb begin
    next_path_config     = path_config;
    next_c2_value        = c2_value;
    next_k3_value        = k3_value;
    next_rdi_value       = rdi_value;
    next_trace_sw_access = trace_sw_access;
    next_trace_ptr_clear = trace_ptr_clear;
    next_trace_ptr       = trace_ptr;
    next_inv_once_done   = inv_once_done;
    next_pready          = psel & penable & ~pready;
    next_prdata          = 32'h0000_0000;
    next_pslverr         = 1'b0;
    if (psel & penable & ~pready) begin
      unique case (paddr)
        reg_addr(IDX_PATH_CONFIG): next_prdata[7:0] = path_config;
        reg_addr(IDX_C2_VALUE):    next_prdata[7:0] = c2_value;
        reg_addr(IDX_K3_VALUE):    next_prdata[7:0] = k3_value;
        reg_addr(IDX_RDI_VALUE):   next_prdata[3:0] = rdi_value;
        reg_addr(IDX_TRACE_CTL):   next_prdata      = 32'h0000_0000;
        reg_addr(IDX_TRACE_DATA):  next_prdata[7:0] = trace_mem[trace_ptr];
        default:                   next_pslverr     = 1'b1;
      endcase
    end
    // Hardware advances one byte per frame at J1 while it owns the string.
    if (j1_take & ~trace_sw_access) begin
      next_trace_ptr = ptr_step(trace_ptr, trace_len_sel);
    end
    // A one-frame inversion is consumed at the B3 slot it was applied to.
    if (b3_slot & (parity_invert_ctl == INV_ONCE)) begin
      next_inv_once_done = 1'b1;
    end
    if (acc_done & pwrite) begin
      unique case (paddr)
        reg_addr(IDX_PATH_CONFIG): begin
          next_path_config   = pwdata[7:0];
          next_inv_once_done = 1'b0;
        end
        reg_addr(IDX_C2_VALUE):  next_c2_value = pwdata[7:0];
        reg_addr(IDX_K3_VALUE):  next_k3_value = pwdata[7:0];
        reg_addr(IDX_RDI_VALUE): next_rdi_value = pwdata[3:0];
        reg_addr(IDX_TRACE_CTL): begin
          next_trace_sw_access = pwdata[CTL_ACCESS];
          next_trace_ptr_clear = pwdata[CTL_PTR_CLEAR];
        end
        default: next_trace_ptr_clear = trace_ptr_clear;
      endcase
    end
    // Processor accesses move the pointer only in access mode.
    if (acc_done & hit_data & trace_sw_access) begin
      next_trace_ptr = ptr_step(trace_ptr, trace_len_sel);
    end
    // A rising edge of the clear bit wins over any advance in the same cycle.
    if (acc_done & pwrite & (paddr == reg_addr(IDX_TRACE_CTL)) &
        pwdata[CTL_PTR_CLEAR] & ~trace_ptr_clear) begin
      next_trace_ptr = 6'h00;
    end
  end

  // Register the bus-side state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      path_config     <= RST_PATH_CONFIG;
      c2_value        <= RST_C2_VALUE;
      k3_value        <= RST_K3_VALUE;
      rdi_value       <= RST_RDI_VALUE;
      trace_sw_access <= RST_SW_ACCESS;
      trace_ptr_clear <= 1'b0;
      trace_ptr       <= 6'h00;
      inv_once_done   <= 1'b0;
      pready          <= 1'b0;
      prdata          <= 32'h0000_0000;
      pslverr         <= 1'b0;
    end else begin
      path_config     <= next_path_config;
      c2_value        <= next_c2_value;
      k3_value        <= next_k3_value;
      rdi_value       <= next_rdi_value;
      trace_sw_access <= next_trace_sw_access;
      trace_ptr_clear <= next_trace_ptr_clear;
      trace_ptr       <= next_trace_ptr;
      inv_once_done   <= next_inv_once_done;
      pready          <= next_pready;
      prdata          <= next_prdata;
      pslverr         <= next_pslverr;
    end
  end

  // Trace memory; writes are ignored while hardware owns the string.
  always_ff @(posedge clk) begin
    if (acc_done & pwrite & hit_data & trace_sw_access) begin
      trace_mem[trace_ptr] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Overhead byte generation
  // ---------------------------------------------------------------------------
  logic [2:0] hw_rdi;
  logic [3:0] g1_low;
  logic [3:0] g1_rei;
  logic [7:0] next_poh_byte;
  logic       next_poh_byte_valid;
  logic       pass_all;

  // Hardware RDI priority chain: server defect, then label, then connectivity.
  always_comb begin
    if (au_alarm_status | pointer_loss_status) begin
      hw_rdi = RDI_SERVER;
    end else if (rdi_on_label_mismatch_en & label_mismatch_status) begin
      hw_rdi = RDI_LABEL;
    end else if ((rdi_on_unequipped_en & unequipped_rx_status) | trace_mismatch_status) begin
      hw_rdi = RDI_CONNECT;
    end else begin
      hw_rdi = RDI_NONE;
    end
  end

  assign g1_low   = rdi_source_sel ? rdi_value : {hw_rdi, 1'b0};
  assign g1_rei   = rei_source_sel ? 4'h0 : b3_err_count;
  assign pass_all = regen_mode | poh_passthru_sel;

  // Select the byte for the current slot.
  always_comb begin
    next_poh_byte       = poh_byte;
    next_poh_byte_valid = slot_valid;
    if (slot_valid) begin
      if (pass_all) begin
        next_poh_byte = force_path_ais ? BYTE_ONES : rx_poh_byte;
      end else begin
        unique case (slot_sel)
          SLOT_J1: begin
            if (send_unequipped & unequipped_trace_zero) begin
              next_poh_byte = BYTE_ZERO;
            end else if (trace_byte_source) begin
              next_poh_byte = tpoh_byte;
            end else if (trace_sw_access) begin
              next_poh_byte = TRACE_IDLE;
            end else begin
              next_poh_byte = trace_mem[trace_ptr];
            end
          end
          SLOT_B3: begin
            // Parity stays valid when unequipped; only the test inversion alters it.
            if (parity_invert_ctl == INV_FOREVER) begin
              next_poh_byte = ~b3_calc;
            end else if ((parity_invert_ctl == INV_ONCE) & ~inv_once_done) begin
              next_poh_byte = ~b3_calc;
            end else begin
              next_poh_byte = b3_calc;
            end
          end
          SLOT_C2: begin
            if (send_unequipped) begin
              next_poh_byte = BYTE_ZERO;
            end else begin
              next_poh_byte = label_byte_source ? tpoh_byte : c2_value;
            end
          end
          SLOT_G1: begin
            next_poh_byte = status_byte_source ? tpoh_byte : {g1_rei, g1_low};
          end
          SLOT_K3: next_poh_byte = aps_byte_source ? tpoh_byte : k3_value;
          SLOT_N1: next_poh_byte = send_unequipped ? BYTE_ZERO : tpoh_byte;
          default: next_poh_byte = tpoh_byte;
        endcase
      end
    end
  end

  // Register the generated byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      poh_byte       <= BYTE_ZERO;
      poh_byte_valid <= 1'b0;
      path_ais_out   <= 1'b0;
    end else begin
      poh_byte       <= next_poh_byte;
      poh_byte_valid <= next_poh_byte_valid;
      path_ais_out   <= force_path_ais & poh_passthru_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // Telecom-bus frame marker
  // ---------------------------------------------------------------------------
  logic [1:0] mark_cnt;
  logic [1:0] next_mark_cnt;
  logic       next_marker;

  // A double pulse is J1 high, one low cycle, then high again.
  always_comb begin
    next_mark_cnt = (mark_cnt != 2'h0) ? mark_cnt - 2'h1 : 2'h0;
    next_marker   = (mark_cnt == 2'h1);
    if (j1_take) begin
      next_marker = 1'b1;
      if (path_config[CFG_MARKER] & (mframe_phase == MFRAME_START)) begin
        next_mark_cnt = MARK_GAP;
      end
    end
  end

  // Register the marker.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_cnt              <= 2'h0;
      tbus_frame_marker_out <= 1'b0;
    end else begin
      mark_cnt              <= next_mark_cnt;
      tbus_frame_marker_out <= next_marker;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_marker_double: assert property (
    (j1_take & path_config[CFG_MARKER] & (mframe_phase == MFRAME_START))
      |=> tbus_frame_marker_out ##1 !tbus_frame_marker_out ##1 tbus_frame_marker_out)
    else $error("double marker pulse missing");
  a_marker_single: assert property (
    (j1_take & ~path_config[CFG_MARKER] & (mark_cnt == 2'h0)) |=> tbus_frame_marker_out ##1
      (!tbus_frame_marker_out || $past(j1_take)))
    else $error("single marker pulse wrong");
  a_unequipped_c2: assert property (
    (slot_valid & (slot_sel == SLOT_C2) & send_unequipped & ~pass_all) |=> poh_byte == 8'h00)
    else $error("unequipped C2 not zero");
  a_ais_force: assert property (
    (slot_valid & force_path_ais & poh_passthru_sel) |=> poh_byte == 8'hFF && path_ais_out)
    else $error("forced AIS not sent");
  a_rdi_server: assert property (
    (slot_valid & (slot_sel == SLOT_G1) & ~pass_all & ~status_byte_source & ~rdi_source_sel &
     (au_alarm_status | pointer_loss_status)) |=> poh_byte[3:0] == 4'hA)
    else $error("server RDI not sent");
  a_rei_zero: assert property (
    (slot_valid & (slot_sel == SLOT_G1) & ~pass_all & ~status_byte_source & rei_source_sel)
      |=> poh_byte[7:4] == 4'h0)
    else $error("REI not forced to zero");
  a_c2_insert: assert property (
    (slot_valid & (slot_sel == SLOT_C2) & ~pass_all & ~send_unequipped & ~label_byte_source)
      |=> poh_byte == $past(c2_value))
    else $error("software C2 not inserted");
  a_access_idle: assert property (
    (j1_take & ~pass_all & trace_sw_access & ~trace_byte_source &
     ~(send_unequipped & unequipped_trace_zero)) |=> poh_byte == 8'h01)
    else $error("J1 idle value wrong");
  a_ptr_hold: assert property (
    (acc_done & hit_data & ~trace_sw_access & ~j1_take) |=> $stable(trace_ptr))
    else $error("processor moved pointer");
  a_ptr_wrap: assert property (
    (j1_take & ~trace_sw_access & ~trace_len_sel & (trace_ptr == 6'h0F) & ~acc_done)
      |=> trace_ptr == 6'h00)
    else $error("short string did not wrap");

endmodule : thpog_top

// [sim/thpog_framer.sv]
// Purpose: Framer model strobing six overhead slots a frame.
// Assumes: One slot every 4 cycles, 24 cycles a frame.
// Notes: Lowering run restarts the next frame at J1.
`timescale 1ns/100ps
module thpog_framer
  import thpog_pkg::*;
(
  input  wire logic   clk,          // Clock.
  input  wire logic   rst_n,        // Reset, active low.
  input  wire logic   run,          // Frames flow while high.
  output logic        slot_valid,   // Slot strobe.
  output thpog_slot_t slot_sel,     // Slot code.
  output logic [1:0]  mframe_phase  // Multiframe phase.
);
  localparam thpog_slot_t SEQ [6] = '{SLOT_J1, SLOT_B3, SLOT_C2, SLOT_G1, SLOT_K3, SLOT_N1};
  logic [4:0] cnt;
  // Phase steps once a frame, so a multiframe start recurs every fourth frame.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {cnt, mframe_phase} <= 7'h00;
    else begin
      cnt <= (!run || cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
      if (run && cnt == 5'h17) mframe_phase <= mframe_phase + 2'h1;
    end
  assign slot_valid = run && cnt[1:0] == 2'h0;
  assign slot_sel = SEQ[cnt[4:2]];
endmodule // thpog_framer

// [sim/thpog_top_test.sv]
// Purpose: Self-checking bench for the path overhead generator.
// Assumes: Registers change only while frames are stopped.
// Notes: A reference function predicts every overhead byte.
`timescale 1ns/100ps
module thpog_top_test;
  import thpog_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, run = 0, perr, pready, pslverr;
  logic regen_mode = 0, poh_passthru_sel = 0, trace_byte_source = 0, poh_byte_valid;
  logic slot_valid, path_ais_out, tbus_frame_marker_out, acc = 1, armed = 1, em = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] rx_poh_byte = 0, tpoh_byte = 0, b3_calc = 0, poh_byte, exp_b, rd, cfg, mem [64];
  logic [7:0] sw [3] = '{8'h01, 8'h00, 8'h00};
  logic [3:0] b3_err_count = 0;
  logic [10:0] st = 0;
  logic [5:0] ptr = 0;
  logic [1:0] mframe_phase, mk = 0;
  thpog_slot_t slot_sel;
  integer seed = 32'h1d3ffa22, num_errors = 0, num_checks = 0;
  localparam logic [7:0] RIDX [4] = '{8'h71, 8'h72, 8'h73, 8'h74};
  localparam logic [7:0] RVAL [4] = '{8'h80, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] CFGS [7] = '{8'h80, 8'h02, 8'h03, 8'h48, 8'h2C, 8'h13, 8'h04};
  thpog_top u_dut (.*, .au_alarm_status(st[0]), .pointer_loss_status(st[1]),
    .rdi_on_label_mismatch_en(st[2]), .label_mismatch_status(st[3]),
    .rdi_on_unequipped_en(st[4]), .unequipped_rx_status(st[5]), .trace_mismatch_status(st[6]),
    .status_byte_source(st[7]), .label_byte_source(st[8]), .aps_byte_source(st[9]),
    .unequipped_trace_zero(st[10]));
  thpog_framer u_frm (.clk, .rst_n, .run, .slot_valid, .slot_sel, .mframe_phase);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Expected byte for one slot; the trace pointer and one-shot inversion advance here.
  function automatic logic [7:0] ref_byte(thpog_slot_t s);
    logic [7:0] r;
    logic [2:0] hw;
    r = tpoh_byte;
    hw = (st[0] | st[1]) ? 3'h5 : (st[2] & st[3]) ? 3'h4 : ((st[4] & st[5]) | st[6]) ? 3'h6 : 3'h0;
    if (poh_passthru_sel | regen_mode) return cfg[4] ? 8'hFF : rx_poh_byte;
    case (s)
      SLOT_J1: begin
        if (cfg[6] && st[10]) r = 8'h00;
        else if (!trace_byte_source) r = acc ? 8'h01 : mem[ptr];
        if (!acc) ptr = (ptr == (cfg[5] ? 6'h3F : 6'h0F)) ? 6'h00 : ptr + 6'h01;
      end
      SLOT_B3: begin
        r = (cfg[1:0] == 2'h2 || (cfg[1:0] == 2'h3 && armed)) ? ~b3_calc : b3_calc;
        if (cfg[1:0] == 2'h3) armed = 1'b0;
      end
      SLOT_C2: r = cfg[6] ? 8'h00 : st[8] ? tpoh_byte : sw[0];
      SLOT_N1: r = cfg[6] ? 8'h00 : tpoh_byte;
      SLOT_K3: r = st[9] ? tpoh_byte : sw[1];
      SLOT_G1: if (!st[7]) r = {cfg[3] ? 4'h0 : b3_err_count, cfg[2] ? sw[2][3:0] : {hw, 1'b0}};
      default: ;
    endcase
    return r;
  endfunction
  // Predict at the slot edge and drive fresh random data after it.
  always @(posedge clk) begin
    if (slot_valid) exp_b <= ref_byte(slot_sel);
    {rx_poh_byte, tpoh_byte, b3_calc} <= 24'($random(seed));
    b3_err_count <= 4'({$random(seed)} % 9);
    st <= 11'($random(seed));
    trace_byte_source <= acc & 1'($random(seed));
    // Marker model: a double pulse repeats the J1 pulse two cycles later.
    mk <= {mk[0], slot_valid && slot_sel == SLOT_J1 && cfg[7] && mframe_phase == 2'h0};
    em <= (slot_valid && slot_sel == SLOT_J1) || mk[1];
  end
  always @(negedge clk) chk({7'h0, tbus_frame_marker_out}, {7'h0, em});
  always @(negedge clk) if (poh_byte_valid === 1'b1) begin
    chk(poh_byte, exp_b);
    chk({7'h0, path_ais_out}, {7'h0, cfg[4] & poh_passthru_sel});
  end
  // Master holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] idx, d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    rd = prdata[7:0];
    perr = pslverr;
  endtask
  task automatic phase(input logic [7:0] c, input int n);
    cfg = c;
    armed = 1'b1;
    apb(1'b1, IDX_PATH_CONFIG, c);
    run <= 1'b1;
    repeat (n * 24) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (RIDX[i]) begin
      apb(1'b0, RIDX[i], 8'h00);
      chk(rd, RVAL[i]);
    end
    apb(1'b0, 8'h7F, 8'h00);
    chk({7'h0, perr}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      sw[i] = 8'($random(seed)) & (i == 2 ? 8'h0F : 8'hFF);
      apb(1'b1, IDX_C2_VALUE + 8'(i), sw[i]);
      apb(1'b0, IDX_C2_VALUE + 8'(i), 8'h00);
      chk(rd, sw[i]);
    end
    foreach (CFGS[i]) phase(CFGS[i], 4);
    cfg = 8'h20;
    apb(1'b1, IDX_PATH_CONFIG, 8'h20);
    apb(1'b1, IDX_TRACE_CTL, 8'h03);
    foreach (mem[i]) begin
      mem[i] = 8'($random(seed));
      apb(1'b1, IDX_TRACE_DATA, mem[i]);
    end
    apb(1'b1, IDX_TRACE_CTL, 8'h02);
    apb(1'b1, IDX_TRACE_CTL, 8'h03);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, IDX_TRACE_DATA, 8'h00);
      chk(rd, mem[i]);
    end
    apb(1'b1, IDX_TRACE_CTL, 8'h00);
    acc = 1'b0;
    apb(1'b1, IDX_TRACE_DATA, ~mem[0]);
    apb(1'b1, IDX_TRACE_CTL, 8'h01);
    phase(8'h00, 20);
    apb(1'b1, IDX_TRACE_CTL, 8'h01);
    phase(8'h20, 70);
    apb(1'b1, IDX_TRACE_CTL, 8'h02);
    acc = 1'b1;
    poh_passthru_sel <= 1'b1;
    phase(8'h10, 2);
    phase(8'h00, 2);
    poh_passthru_sel <= 1'b0;
    regen_mode <= 1'b1;
    phase(8'h00, 2);
    test_done();
  end
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
endmodule // thpog_top_test
